// *** logic/spp_map.vh ***
`ifndef SPP_MAP_VH
`define SPP_MAP_VH

// clock and time base
`define SPP_CLK_KHZ 20000
`define SPP_TICK_US 1000
`define SPP_TICK_CYC (`SPP_TICK_US * `SPP_CLK_KHZ / 1000)

// rate unit and bucket sizing, in bytes
`define SPP_RATE_UNIT_KBPS 128
`define SPP_BYTES_PER_UNIT (`SPP_RATE_UNIT_KBPS * `SPP_TICK_US / 8000)
`define SPP_BURST_BYTES 24'h004000

// frame length limits
`define SPP_MAX_STD 14'h05ee
`define SPP_MAX_JUMBO 14'h2400

// register byte offsets
`define SPP_A_CTRL 6'h00
`define SPP_A_STAT 6'h04
`define SPP_A_ING 6'h08
`define SPP_A_EGR 6'h0c
`define SPP_A_DROP 6'h10
`define SPP_A_DESC 6'h20

// control fields
`define SPP_C_EN 0
`define SPP_C_FORCE 1
`define SPP_C_SPD 3:2
`define SPP_C_DPX 4
`define SPP_C_FC 5
`define SPP_C_SEC 6
`define SPP_C_STORM 7
`define SPP_C_JUMBO 8
`define SPP_CTRL_BITS 9
`define SPP_CTRL_RST 9'h195

// speed codes
`define SPP_SPD_10 2'h0
`define SPP_SPD_100 2'h1
`define SPP_SPD_1000 2'h2

// pause frames
`define SPP_PAUSE_MAX 16'hffff
`define SPP_PAUSE_OFF 16'h0000
`define SPP_PAUSE_REFRESH 8'h0a

`endif

// *** logic/spp_rate_lim.v ***
`include "spp_map.vh"

module spp_rate_lim (
  // clock and reset
  input wire clk,
  input wire resetn,
  // time base and limit
  input wire tick,
  input wire [15:0] rate,
  // byte usage
  input wire consume,
  output reg ok_q
);

  reg signed [23:0] bucket_q;
  reg signed [23:0] bucket_d;
  wire [31:0] add_full;
  wire [23:0] add;

  assign add_full = {16'h0000, rate} * `SPP_BYTES_PER_UNIT;
  assign add = add_full[23:0];

  // bucket may go negative by one frame; new frames are held (egress) or dropped (ingress) until it refills,
  // so the long-term average stays at the limit without cutting frames
  always @* begin
    bucket_d = bucket_q;
    if (tick) begin
      bucket_d = bucket_d + $signed(add);
    end
    if (consume) begin
      bucket_d = bucket_d - 24'sd1;
    end
    if (rate == 16'h0000 || bucket_d > $signed(`SPP_BURST_BYTES)) begin
      bucket_d = $signed(`SPP_BURST_BYTES);
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      bucket_q <= $signed(`SPP_BURST_BYTES);
      ok_q <= 1'b1;
    end else begin
      bucket_q <= bucket_d;
      ok_q <= (rate == 16'h0000) | ~bucket_d[23];
    end
  end

endmodule

// *** logic/spp_pause_gen.v ***
`include "spp_map.vh"

module spp_pause_gen (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire tick,
  input wire fc_en,
  input wire full,
  input wire congested,
  // pause request to the transmitter
  output reg pause_send_q,
  output reg [15:0] pause_quanta_q,
  output reg pause_on_q
);

  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  reg [7:0] refresh_q;
  wire want;

  // pause frames only exist on full duplex links
  assign want = fc_en & full & congested;

  always @(posedge clk) begin
    if (!resetn) begin
      pause_send_q <= 1'b0;
      pause_quanta_q <= `SPP_PAUSE_OFF;
      pause_on_q <= ST_IDLE;
      refresh_q <= 8'h00;
    end else begin
      pause_send_q <= 1'b0;
      case (pause_on_q)
        ST_IDLE: begin
          if (want) begin
            pause_send_q <= 1'b1;
            pause_quanta_q <= `SPP_PAUSE_MAX;
            pause_on_q <= ST_HOLD;
            refresh_q <= 8'h00;
          end
        end
        ST_HOLD: begin
          if (!want) begin
            pause_send_q <= 1'b1;
            pause_quanta_q <= `SPP_PAUSE_OFF;
            pause_on_q <= ST_IDLE;
          end else if (tick) begin
            // resend before the partner's timer runs out
            if (refresh_q == `SPP_PAUSE_REFRESH - 8'h01) begin
              refresh_q <= 8'h00;
              pause_send_q <= 1'b1;
            end else begin
              refresh_q <= refresh_q + 8'h01;
            end
          end
        end
        default: begin
          pause_on_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** logic/spp_port.v ***
// Functional notes
// RULE1 - a disabled port neither accepts received frames nor transmits any frame
// RULE2 - auto negotiation mode takes speed and duplex from the negotiated result
// RULE3 - forced mode runs the port at the manually set speed and duplex
// RULE4 - speed and duplex fields read negotiated values and ignore writes in auto
// RULE5 - link up or down state is reported for the port
// RULE6 - flow control on: congestion sends a pause frame to halt the sender; the code sends it on full duplex links only
// RULE7 - flow control off: frames arriving under congestion are dropped
// RULE8 - secure mode never learns new source addresses
// RULE9 - secure mode forwards only frames whose source address is already known
// RULE10 - storm filter enabled per port; types and mode come from switch-wide inputs
// RULE11 - jumbo enable lets the port forward jumbo frames
// RULE12 - jumbo frames up to nine kilobytes are forwarded
// RULE13 - independent ingress and egress limits in units of 128 kbit/s
// RULE14 - the port holds a sixteen character description label
// RULE15 - traffic above a limit is held back or dropped; zero means unlimited
`include "spp_map.vh"

module spp_port #(
  parameter TICK_CYCLES = `SPP_TICK_CYC
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register bus
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // phy side
  input wire phy_link,
  input wire an_done,
  input wire [1:0] an_speed,
  input wire an_full,
  output reg phy_an_en,
  output reg [1:0] phy_speed,
  output reg phy_full,
  // switch-wide storm filter setting
  input wire storm_active,
  input wire [2:0] storm_types,
  // receive stream from the mac
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_sof,
  input wire rx_eof,
  input wire rx_bcast,
  input wire rx_mcast,
  input wire rx_ucast_unknown,
  input wire rx_src_known,
  input wire rx_congested,
  // forward stream to the fabric
  output reg fwd_valid,
  output reg [7:0] fwd_data,
  output reg fwd_sof,
  output reg fwd_eof,
  output reg fwd_err,
  output reg learn_req,
  // transmit stream from the fabric
  input wire tx_in_valid,
  input wire [7:0] tx_in_data,
  input wire tx_in_sof,
  input wire tx_in_eof,
  output reg tx_in_ready,
  // transmit stream to the mac
  output reg tx_valid,
  output reg [7:0] tx_data,
  output reg tx_sof,
  output reg tx_eof,
  // pause frame request
  output reg pause_send,
  output reg [15:0] pause_quanta
);

  reg [`SPP_CTRL_BITS-1:0] ctrl_q, ctrl_d;
  reg [15:0] ing_rate_q, egr_rate_q, drop_cnt_q, tick_cnt_q;
  reg [31:0] desc_q [0:3];
  reg [31:0] rd_d;
  reg [13:0] rx_len_q, rx_len_d;
  reg tick_q, rx_keep_q, rx_keep_d, tx_frame_q, tx_frame_d, tx_keep_q;
  reg fwd_valid_d, rx_drop_now, rx_over;
  integer i;

  wire wr_go, en, force_mode, eff_full, storm_hit, ing_ok, egr_ok, tx_acc, pg_send, pg_on;
  wire [31:0] ctrl_wr, ing_wr, egr_wr;
  wire [1:0] eff_speed;
  wire [13:0] max_len;
  wire [15:0] pg_quanta;

  function [31:0] bemerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        bemerge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  function is_desc;
    input [5:0] a;
    begin
      is_desc = (a[5:4] == `SPP_A_DESC >> 4) && (a[1:0] == 2'h0);
    end
  endfunction

  assign en = ctrl_q[`SPP_C_EN];
  assign force_mode = ctrl_q[`SPP_C_FORCE];
  assign eff_speed = force_mode ? ctrl_q[`SPP_C_SPD] : an_speed; // [RULE2] [RULE3]
  assign eff_full = force_mode ? ctrl_q[`SPP_C_DPX] : an_full; // [RULE2] [RULE3]
  assign max_len = ctrl_q[`SPP_C_JUMBO] ? `SPP_MAX_JUMBO : `SPP_MAX_STD; // [RULE11] [RULE12]
  assign storm_hit = ctrl_q[`SPP_C_STORM] & storm_active &
    ((storm_types[0] & rx_bcast) | (storm_types[1] & rx_mcast) |
     (storm_types[2] & rx_ucast_unknown)); // [RULE10]

  // bus slave: one wait cycle, then a single low waitrequest cycle
  assign wr_go = avs_write & ~avs_waitrequest;
  assign ctrl_wr = bemerge({23'h000000, ctrl_q}, avs_writedata, avs_byteenable);
  assign ing_wr = bemerge({16'h0000, ing_rate_q}, avs_writedata, avs_byteenable);
  assign egr_wr = bemerge({16'h0000, egr_rate_q}, avs_writedata, avs_byteenable);

  always @* begin
    ctrl_d = ctrl_wr[`SPP_CTRL_BITS-1:0];
    if (!ctrl_d[`SPP_C_FORCE]) begin
      ctrl_d[`SPP_C_SPD] = ctrl_q[`SPP_C_SPD]; // [RULE4]
      ctrl_d[`SPP_C_DPX] = ctrl_q[`SPP_C_DPX]; // [RULE4]
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    if (is_desc(avs_address)) begin
      rd_d = desc_q[avs_address[3:2]]; // [RULE14]
    end else begin
      case (avs_address)
        `SPP_A_CTRL: begin
          rd_d = {23'h000000, ctrl_q};
          rd_d[`SPP_C_SPD] = eff_speed; // [RULE4]
          rd_d[`SPP_C_DPX] = eff_full; // [RULE4]
        end
        `SPP_A_STAT: begin
          rd_d = {26'h0000000, an_done, pg_on, eff_full, eff_speed, phy_link}; // [RULE5]
        end
        `SPP_A_ING: rd_d = {16'h0000, ing_rate_q};
        `SPP_A_EGR: rd_d = {16'h0000, egr_rate_q};
        `SPP_A_DROP: rd_d = {16'h0000, drop_cnt_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_d : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= `SPP_CTRL_RST;
      ing_rate_q <= 16'h0000;
      egr_rate_q <= 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        desc_q[i] <= 32'h00000000;
      end
    end else if (wr_go) begin
      if (is_desc(avs_address)) begin
        desc_q[avs_address[3:2]] <= bemerge(desc_q[avs_address[3:2]],
          avs_writedata, avs_byteenable); // [RULE14]
      end else begin
        case (avs_address)
          `SPP_A_CTRL: ctrl_q <= ctrl_d;
          `SPP_A_ING: ing_rate_q <= ing_wr[15:0]; // [RULE13]
          `SPP_A_EGR: egr_rate_q <= egr_wr[15:0]; // [RULE13]
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // phy strap of the negotiation mode
  always @(posedge clk) begin
    if (!resetn) begin
      phy_an_en <= 1'b1;
      phy_speed <= `SPP_SPD_100;
      phy_full <= 1'b1;
    end else begin
      phy_an_en <= ~force_mode; // [RULE2]
      phy_speed <= ctrl_q[`SPP_C_SPD]; // [RULE3]
      phy_full <= ctrl_q[`SPP_C_DPX]; // [RULE3]
    end
  end

  // shared time base for both rate limiters and pause refresh
  always @(posedge clk) begin
    if (!resetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  spp_rate_lim u_ing (
    .clk(clk),
    .resetn(resetn),
    .tick(tick_q),
    .rate(ing_rate_q),
    .consume(fwd_valid_d),
    .ok_q(ing_ok)
  );

  spp_rate_lim u_egr (
    .clk(clk),
    .resetn(resetn),
    .tick(tick_q),
    .rate(egr_rate_q),
    .consume(tx_acc & tx_keep_q & ~tx_in_sof | tx_acc & tx_in_sof & en),
    .ok_q(egr_ok)
  );

  spp_pause_gen u_pause (
    .clk(clk),
    .resetn(resetn),
    .tick(tick_q),
    .fc_en(ctrl_q[`SPP_C_FC] & en),
    .full(eff_full),
    .congested(rx_congested),
    .pause_send_q(pg_send),
    .pause_quanta_q(pg_quanta),
    .pause_on_q(pg_on)
  ); // [RULE6]

  // receive admission is decided at the first byte; with no buffer a frame
  // that grows past the limit is cut and its last beat flagged in error
  always @* begin
    rx_drop_now = ~en | (ctrl_q[`SPP_C_SEC] & ~rx_src_known) | storm_hit | ~ing_ok |
      (rx_congested & ~ctrl_q[`SPP_C_FC]); // [RULE1] [RULE9] [RULE7] [RULE15]
    rx_keep_d = rx_keep_q;
    rx_len_d = rx_len_q;
    fwd_valid_d = 1'b0;
    if (rx_valid) begin
      if (rx_sof) begin
        rx_keep_d = ~rx_drop_now;
        rx_len_d = 14'h0001;
      end else if (rx_len_q != 14'h3fff) begin
        rx_len_d = rx_len_q + 14'h0001;
      end
    end
    rx_over = rx_len_d > max_len; // [RULE12]
    if (rx_valid & rx_keep_d) begin
      fwd_valid_d = ~rx_over | rx_eof;
    end
    if (rx_valid & rx_eof) begin
      rx_keep_d = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      rx_keep_q <= 1'b0;
      rx_len_q <= 14'h0000;
      drop_cnt_q <= 16'h0000;
      fwd_valid <= 1'b0;
      fwd_data <= 8'h00;
      fwd_sof <= 1'b0;
      fwd_eof <= 1'b0;
      fwd_err <= 1'b0;
      learn_req <= 1'b0;
    end else begin
      rx_keep_q <= rx_keep_d;
      rx_len_q <= rx_len_d;
      if (rx_valid & rx_sof & rx_drop_now & (drop_cnt_q != 16'hffff)) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001; // [RULE7]
      end
      fwd_valid <= fwd_valid_d;
      fwd_data <= rx_data;
      fwd_sof <= fwd_valid_d & rx_sof;
      fwd_eof <= fwd_valid_d & rx_eof;
      fwd_err <= fwd_valid_d & rx_eof & rx_over; // [RULE12]
      learn_req <= fwd_valid_d & rx_eof & ~rx_over & ~ctrl_q[`SPP_C_SEC]; // [RULE8]
    end
  end

  // transmit: frames are held at their boundary while over the egress limit;
  // a disabled port still drains the fabric so it cannot lock up
  assign tx_acc = tx_in_valid & tx_in_ready;

  always @* begin
    tx_frame_d = tx_frame_q;
    if (tx_acc) begin
      tx_frame_d = (tx_in_sof | tx_frame_q) & ~tx_in_eof;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      tx_frame_q <= 1'b0;
      tx_keep_q <= 1'b0;
      tx_in_ready <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
      pause_send <= 1'b0;
      pause_quanta <= `SPP_PAUSE_OFF;
    end else begin
      tx_frame_q <= tx_frame_d;
      tx_in_ready <= tx_frame_d | ~en | egr_ok; // [RULE15]
      if (tx_acc & tx_in_sof) begin
        tx_keep_q <= en; // [RULE1]
      end
      tx_valid <= tx_acc & (tx_in_sof ? en : tx_keep_q); // [RULE1]
      tx_data <= tx_in_data;
      tx_sof <= tx_acc & tx_in_sof & en;
      tx_eof <= tx_acc & tx_in_eof & (tx_in_sof ? en : tx_keep_q);
      pause_send <= pg_send & en; // [RULE6]
      pause_quanta <= pg_quanta;
    end
  end

endmodule

// *** testbench/spp_port_properties.sv ***
module spp_port_chk #(
  parameter TICK_CYCLES = 20000
) (
  // clock and reset
  input logic clk,
  input logic resetn,
  // register bus
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  // receive and forward
  input logic rx_valid,
  input logic [7:0] rx_data,
  input logic rx_sof,
  input logic rx_eof,
  input logic fwd_valid,
  input logic [7:0] fwd_data,
  input logic fwd_sof,
  input logic fwd_eof,
  input logic fwd_err,
  input logic learn_req,
  // transmit
  input logic tx_in_valid,
  input logic tx_in_ready,
  input logic tx_valid,
  // pause
  input logic pause_send,
  input logic [15:0] pause_quanta
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // one-cycle ack, then idle again so a held request is not taken twice
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack");
  property p_fwd;
    fwd_valid |-> $past(rx_valid) && fwd_data == $past(rx_data);
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd beat");
  property p_sof;
    fwd_sof |-> fwd_valid && $past(rx_sof);
  endproperty
  a_sof: assert property (p_sof) else $error("fwd sof");
  property p_eof;
    fwd_eof |-> $past(rx_eof && rx_valid);
  endproperty
  a_eof: assert property (p_eof) else $error("fwd eof");
  property p_learn;
    learn_req |-> fwd_eof && !fwd_err;
  endproperty
  a_learn: assert property (p_learn) else $error("learn");
  property p_tx;
    tx_valid |-> $past(tx_in_valid && tx_in_ready);
  endproperty
  a_tx: assert property (p_tx) else $error("tx beat");
  property p_pulse;
    pause_send |=> !pause_send;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pause pulse");
  property p_quanta;
    pause_send |-> pause_quanta == 16'hffff || pause_quanta == 16'h0000;
  endproperty
  a_quanta: assert property (p_quanta) else $error("pause quanta");
endmodule

bind spp_port spp_port_chk #(.TICK_CYCLES(TICK_CYCLES)) spp_port_chk_i (.*);

// *** testbench/spp_link_partner.sv ***
module spp_link_partner (
  // clock
  input logic clk,
  // phy status
  output logic phy_link,
  output logic an_done,
  output logic [1:0] an_speed,
  output logic an_full,
  // receive stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_bcast,
  output logic rx_mcast,
  output logic rx_ucast_unknown,
  output logic rx_src_known
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  // bytes past this length are cut by the port, except the last one
  int lim = 9216;
  initial begin
    {phy_link, an_done, an_full, rx_valid, rx_sof, rx_eof} = 0;
    {rx_bcast, rx_mcast, rx_ucast_unknown, rx_src_known} = 0;
    an_speed = 2'h1;
    rx_data = 8'h00;
  end
  task link(input logic up, input logic [1:0] s, input logic f);
    @(posedge clk);
    phy_link <= up;
    an_done <= up;
    an_speed <= s;
    an_full <= f;
  endtask
  // fl is {src known, unknown ucast, mcast, bcast}; kept bytes queue for the bench
  task send(input int n, input logic [7:0] b, input logic keep, input logic [3:0] fl);
    logic [7:0] d;
    d = b;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1;
      rx_sof <= i == 0;
      rx_eof <= i == n - 1;
      rx_data <= d;
      {rx_src_known, rx_ucast_unknown, rx_mcast, rx_bcast} <= fl;
      if (keep && (i < lim || i == n - 1)) q.push_back(d);
      d = d + 8'h01;
    end
    @(posedge clk);
    {rx_valid, rx_sof, rx_eof} <= 0;
    // idle line shows no stale byte
    rx_data <= ~d;
  endtask
endmodule

// *** testbench/switch_port_policy_bench.sv ***
module switch_port_policy_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic resetn = 0;
  logic [5:0] avs_address, a;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [31:0] rnd = 32'hb5aa;
  logic [3:0] avs_byteenable;
  logic phy_link, an_done, an_full, phy_an_en, phy_full, storm_active;
  logic [1:0] an_speed, phy_speed;
  logic [2:0] storm_types;
  logic rx_valid, rx_sof, rx_eof, rx_bcast, rx_mcast, rx_ucast_unknown, rx_src_known;
  logic rx_congested, fwd_valid, fwd_sof, fwd_eof, fwd_err, learn_req;
  logic [7:0] rx_data, fwd_data, tx_in_data, tx_data;
  logic tx_in_valid, tx_in_sof, tx_in_eof, tx_in_ready, tx_valid, tx_sof, tx_eof;
  logic pause_send;
  logic [15:0] pause_quanta, pz_q;
  logic [31:0] fx;
  logic [9:0] txq[$];
  int failures = 0, compares = 0, lrn_n = 0, exp_l = 0, tx_n = 0, pz_n = 0, drops = 0;
  int err_n = 0;
  always #25 clk = ~clk;
  spp_port #(.TICK_CYCLES(50)) spp_port_i (.*);
  spp_link_partner spp_link_partner_i (.*);
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task conclude;
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= ad;
    avs_writedata <= d;
    // only the watchdog ends a wait for the answer
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task rd(input logic [5:0] ad, input logic [31:0] e, input string n);
    bus(0, ad, 0);
    chk(n, r, e);
  endtask
  task frm(input int n, input logic keep, input logic [3:0] fl, input logic l);
    rnd = lfsr(rnd);
    spp_link_partner_i.send(n, rnd[7:0], keep, fl);
    drops += !keep;
    exp_l += l;
    repeat (3) @(posedge clk);
  endtask
  task txf(input int n, input logic keep);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      tx_in_valid <= 1;
      tx_in_sof <= i == 0;
      tx_in_eof <= i == n - 1;
      tx_in_data <= rnd[7:0];
      if (keep) txq.push_back({i == n - 1, i == 0, rnd[7:0]});
      do @(posedge clk); while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 0;
    repeat (3) @(posedge clk);
  endtask
  // forwarded bytes must match what the partner sent on kept frames, in order
  always @(posedge clk) begin
    if (fwd_valid === 1'b1) begin
      fx = spp_link_partner_i.q.size() ? spp_link_partner_i.q.pop_front() : 32'h100;
      chk("fwd", fwd_data, fx);
    end
    if (tx_valid === 1'b1) begin
      tx_n++;
      fx = txq.size() ? txq.pop_front() : 32'h400;
      chk("tx", {tx_eof, tx_sof, tx_data}, fx);
    end
    lrn_n += (learn_req === 1'b1);
    err_n += (fwd_err === 1'b1);
    if (pause_send === 1'b1) begin
      pz_n++;
      pz_q = pause_quanta;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    {avs_read, avs_write, rx_congested, storm_active, tx_in_valid, tx_in_sof, tx_in_eof} = 0;
    avs_address = 6'h00;
    avs_writedata = 0;
    avs_byteenable = 4'hf;
    storm_types = 3'h1;
    tx_in_data = 8'h00;
    repeat (4) @(posedge clk);
    resetn <= 1;
    rd(6'h00, 32'h185, "ctrl_rst");
    rd(6'h3c, 0, "unmapped");
    spp_link_partner_i.link(1, 2'h2, 0);
    repeat (2) @(posedge clk);
    rd(6'h04, 32'h25, "status");
    rd(6'h00, 32'h189, "ctrl_auto");
    bus(1, 6'h00, 32'h19d);
    rd(6'h00, 32'h189, "ctrl_ro");
    bus(1, 6'h00, 32'h193);
    rd(6'h00, 32'h193, "ctrl_force");
    chk("phy", {phy_an_en, phy_speed, phy_full}, 4'h1);
    for (a = 6'h20; a < 6'h30; a = a + 6'h04) begin
      rnd = lfsr(rnd);
      bus(1, a, rnd);
      rd(a, rnd, "desc");
    end
    bus(1, 6'h08, 32'hffff0005);
    rd(6'h08, 32'h5, "ingress");
    bus(1, 6'h0c, 32'h9);
    rd(6'h0c, 32'h9, "egress");
    bus(1, 6'h08, 0);
    frm(5, 1, 4'h8, 1);
    bus(1, 6'h00, 32'h1d3);
    frm(4, 0, 4'h0, 0);
    frm(3, 1, 4'h8, 0);
    bus(1, 6'h00, 32'h192);
    frm(3, 0, 4'h8, 0);
    txf(3, 0);
    bus(1, 6'h00, 32'h193);
    txf(4, 1);
    chk("tx_n", tx_n, 4);
    // jumbo off: a frame past the standard limit is cut and flagged, never learned
    bus(1, 6'h00, 32'h093);
    spp_link_partner_i.lim = 1518;
    frm(1520, 1, 4'h8, 0);
    chk("err", err_n, 1);
    storm_active <= 1;
    frm(2, 0, 4'h9, 0);
    frm(2, 1, 4'h8, 1);
    bus(1, 6'h00, 32'h113);
    frm(2, 1, 4'h9, 1);
    storm_active <= 0;
    rx_congested <= 1;
    frm(2, 0, 4'h8, 0);
    rx_congested <= 0;
    chk("learn", lrn_n, exp_l);
    chk("left", spp_link_partner_i.q.size(), 0);
    chk("tx_left", txq.size(), 0);
    rd(6'h10, drops, "drops");
    bus(1, 6'h00, 32'h133);
    rx_congested <= 1;
    repeat (10) @(posedge clk);
    chk("pz_on", {pz_n[3:0], pz_q}, 20'h1ffff);
    rx_congested <= 0;
    repeat (10) @(posedge clk);
    chk("pz_off", {pz_n[3:0], pz_q}, 20'h20000);
    spp_link_partner_i.link(0, 2'h1, 1);
    repeat (2) @(posedge clk);
    bus(0, 6'h04, 0);
    chk("link", r[0], 0);
    conclude();
  end
endmodule
